// >>> core/audio_tx_defs.svh
// Offsets, field positions, reset values and timing counts of the transmit slot block.
`ifndef AUDIO_TX_DEFS_SVH
`define AUDIO_TX_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TX_OFS_MASK 3'h0
`define TX_OFS_IRQEN 3'h1
`define TX_OFS_STATUS 3'h2
`define TX_OFS_SLOT 3'h3
`define TX_OFS_CTRL 3'h4
// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define TX_RST_WORD 32'h0000_0000
`define TX_IRQEN_WMASK 8'hbf
`define TX_STAT_WMASK 8'hf7
`define TX_ST_UNDER 0
`define TX_ST_SYNC 1
`define TX_ST_CLK 2
`define TX_ST_PAR 3
`define TX_ST_LAST 4
`define TX_ST_DRDY 5
`define TX_ST_SOF 6
`define TX_ST_DMA 7
`define TX_ST_ERR 8
`define TX_EN_SOF 7
`define TX_CTRL_REL 0
`define TX_CTRL_LAST_LO 4
`define TX_CTRL_LAST_HI 12
`define TX_CTRL_SER_LO 16
`define TX_CTRL_SER_HI 19
// ----------------------------------------------------------------------------
// Slot timing
// ----------------------------------------------------------------------------
`define TX_SLOT_MAX 9'd383
`define TX_SLOT_RST 9'd383
`define TX_BIT_LAST 5'd31
`endif

// >>> core/audio_tx_pkg.sv
// Types shared by the transmit slot block.
package audio_tx_pkg;
   typedef enum logic [1:0] {LINK_OFF, LINK_WAIT, LINK_RUN} link_state_t;
   typedef logic [8:0] slot_t;
endpackage

// >>> core/tx_pin_sync.sv
// Two-flop synchronisers for the link pins.
module tx_pin_sync (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_async,
   output logic [1:0] o_sync
);
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_bit
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= i_async[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate
   assign o_sync = sync_q;
endmodule

// >>> core/audio_tx_slot_irq_status.sv
// Transmit slot mask, interrupt enables and status flags with a one-word serializer.
`include "audio_tx_defs.svh"
module audio_tx_slot_irq_status
   import audio_tx_pkg::*;
(
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic [4:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   input wire logic I_DMA_WRITE,
   input wire logic [31:0] I_DMA_WRITEDATA,
   input wire logic I_CLK_FAULT,
   input wire logic I_TX_BIT_CLK,
   input wire logic I_TX_FRAME_SYNC,
   output logic O_TX_DATA,
   output logic O_TX_DATA_OE,
   output logic O_TX_DMA_REQ,
   output logic O_TX_IRQ
);
   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] mask_q;
   logic [7:0] irqen_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [19:0] ctrl_q;
   slot_t slot_q;
   slot_t slot_d;
   logic [4:0] bit_q;
   logic [31:0] shreg_q;
   logic [31:0] buf_q;
   logic buf_full_q;
   logic [4:0] dma_cnt_q;
   logic rel_q;
   logic oe_q;
   logic dma_req_q;
   logic irq_q;
   logic bclk_prev_q;
   logic fs_prev_q;
   link_state_t link_q;
   link_state_t link_d;

   // -------------------------------------------------------------------------
   // Pin synchronisers and edge detect
   // -------------------------------------------------------------------------
   logic [1:0] pins_sync;
   tx_pin_sync tx_pin_sync_inst (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_async({I_TX_FRAME_SYNC, I_TX_BIT_CLK}),
      .o_sync(pins_sync)
   );
   wire bclk_rise = pins_sync[0] & ~bclk_prev_q;
   // Frame sync is judged at bit clock rises only, so it lines up with the shift edge.
   wire fs_rise = pins_sync[1] & ~fs_prev_q;

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   wire req = I_AVS_READ | I_AVS_WRITE;
   wire [2:0] word_sel = I_AVS_ADDRESS[4:2];
   wire wr_fire = I_AVS_WRITE & ack_q;
   wire [31:0] be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                          {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
   wire [31:0] wdata_m = I_AVS_WRITEDATA & be_mask;
   wire wr_mask = wr_fire & (word_sel == `TX_OFS_MASK);
   wire wr_irqen = wr_fire & (word_sel == `TX_OFS_IRQEN);
   wire wr_status = wr_fire & (word_sel == `TX_OFS_STATUS);
   wire wr_ctrl = wr_fire & (word_sel == `TX_OFS_CTRL);
   wire [7:0] clr = wr_status ? (wdata_m[7:0] & `TX_STAT_WMASK) : 8'h00;

   // -------------------------------------------------------------------------
   // Control fields
   // -------------------------------------------------------------------------
   wire rel = ctrl_q[`TX_CTRL_REL];
   wire [8:0] last_slot = ctrl_q[`TX_CTRL_LAST_HI:`TX_CTRL_LAST_LO];
   wire [4:0] ser_cnt = {1'b0, ctrl_q[`TX_CTRL_SER_HI:`TX_CTRL_SER_LO]};

   // -------------------------------------------------------------------------
   // Slot timing
   // -------------------------------------------------------------------------
   wire running = (link_q == LINK_RUN);
   wire bit_last = (bit_q == `TX_BIT_LAST);
   wire slot_wrap = (slot_q == last_slot) | (slot_q == `TX_SLOT_MAX);
   wire frame_end = running & bit_last & (slot_q == last_slot);
   wire sync_ok = (link_q == LINK_WAIT) | frame_end;
   wire xfer = bclk_rise & rel & (fs_rise | (running & bit_last));
   wire [8:0] slot_inc = slot_wrap ? 9'd0 : slot_q + 9'd1;
   wire [8:0] slot_next = fs_rise ? 9'd0 : slot_inc;

   always_comb begin
      link_d = link_q;
      case (link_q)
         LINK_OFF: begin
            if (rel) begin
               link_d = LINK_WAIT;
            end
         end
         LINK_WAIT: begin
            if (!rel) begin
               link_d = LINK_OFF;
            end else if (bclk_rise & fs_rise) begin
               link_d = LINK_RUN;
            end
         end
         LINK_RUN: begin
            if (!rel) begin
               link_d = LINK_OFF;
            end
         end
         default: begin
            link_d = LINK_OFF;
         end
      endcase
   end

   always_comb begin
      slot_d = slot_q;
      if (!rel) begin
         slot_d = `TX_SLOT_RST;
      end else if (xfer) begin
         slot_d = slot_next;
      end
   end

   // -------------------------------------------------------------------------
   // Flag events
   // -------------------------------------------------------------------------
   wire ev_release = rel & ~rel_q;
   wire ev_move = xfer & buf_full_q;
   wire ev_drdy = ev_release | ev_move;
   wire ev_last = ev_move & (slot_next == last_slot);
   wire ev_under = xfer & ~buf_full_q;
   wire ev_sof = bclk_rise & rel & fs_rise;
   wire ev_sync = ev_sof & ~sync_ok;
   // A write that lands together with the transfer belongs to the new slot.
   wire ev_dma = I_DMA_WRITE & ~xfer & (dma_cnt_q >= ser_cnt);
   wire [7:0] set_vec;
   assign set_vec[`TX_ST_UNDER] = ev_under;
   assign set_vec[`TX_ST_SYNC] = ev_sync;
   assign set_vec[`TX_ST_CLK] = I_CLK_FAULT;
   assign set_vec[`TX_ST_PAR] = 1'b0;
   assign set_vec[`TX_ST_LAST] = ev_last;
   assign set_vec[`TX_ST_DRDY] = ev_drdy;
   assign set_vec[`TX_ST_SOF] = ev_sof;
   assign set_vec[`TX_ST_DMA] = ev_dma;
   assign flags_d = (flags_q & ~clr) | set_vec;

   // -------------------------------------------------------------------------
   // Interrupt
   // -------------------------------------------------------------------------
   // Enable and flag layouts differ for start of frame and DMA error, and parity has no enable bit.
   function automatic logic [7:0] en_to_flags(input logic [7:0] en);
      en_to_flags = en;
      en_to_flags[`TX_ST_SOF] = en[`TX_EN_SOF];
      en_to_flags[`TX_ST_DMA] = en[`TX_ST_DMA - 4];
      en_to_flags[`TX_ST_PAR] = 1'b0;
   endfunction
   wire [7:0] en_map = en_to_flags(irqen_q);
   wire [7:0] pend_d = flags_d & en_map;
   // The interrupt line drops for one cycle so an edge-sensitive controller sees a new edge.
   wire collide = |(set_vec & clr & en_map);
   wire err_sum = flags_q[`TX_ST_UNDER] | flags_q[`TX_ST_SYNC] |
                  flags_q[`TX_ST_CLK] | flags_q[`TX_ST_DMA];

   // -------------------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------------------
   wire [31:0] status_word = {23'h0, err_sum, flags_q[7:4], slot_q[0], flags_q[2:0]};
   always_comb begin
      rdata_d = `TX_RST_WORD;
      case (word_sel)
         `TX_OFS_MASK: rdata_d = mask_q;
         `TX_OFS_IRQEN: rdata_d = {24'h0, irqen_q};
         `TX_OFS_STATUS: rdata_d = status_word;
         `TX_OFS_SLOT: rdata_d = {23'h0, slot_q};
         `TX_OFS_CTRL: rdata_d = {12'h0, ctrl_q};
         default: rdata_d = `TX_RST_WORD;
      endcase
   end

   // -------------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------------
   // Every access takes exactly one wait cycle, read data is registered in it.
   assign O_AVS_WAITREQUEST = req & ~ack_q;
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         ack_q <= 1'b0;
         rdata_q <= `TX_RST_WORD;
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= (I_AVS_READ & ~ack_q) ? rdata_d : rdata_q;
      end
   end
   assign O_AVS_READDATA = rdata_q;

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         mask_q <= `TX_RST_WORD;
         irqen_q <= 8'h00;
         ctrl_q <= 20'h0;
         flags_q <= 8'h00;
      end else begin
         if (wr_mask) begin
            mask_q <= (mask_q & ~be_mask) | wdata_m;
         end
         if (wr_irqen) begin
            irqen_q <= ((irqen_q & ~be_mask[7:0]) | wdata_m[7:0]) & `TX_IRQEN_WMASK;
         end
         if (wr_ctrl) begin
            ctrl_q <= (ctrl_q & ~be_mask[19:0]) | wdata_m[19:0];
         end
         flags_q <= flags_d;
      end
   end

   // -------------------------------------------------------------------------
   // Link side
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         bclk_prev_q <= 1'b0;
         fs_prev_q <= 1'b0;
         rel_q <= 1'b0;
         link_q <= LINK_OFF;
         slot_q <= `TX_SLOT_RST;
      end else begin
         bclk_prev_q <= pins_sync[0];
         if (bclk_rise) begin
            fs_prev_q <= pins_sync[1];
         end
         rel_q <= rel;
         link_q <= link_d;
         slot_q <= slot_d;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N || !rel) begin
         bit_q <= 5'd0;
      end else if (xfer) begin
         bit_q <= 5'd0;
      end else if (bclk_rise & running) begin
         bit_q <= bit_q + 5'd1;
      end
   end

   // An underrun shifts out zeros rather than repeating stale data.
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         shreg_q <= `TX_RST_WORD;
      end else if (xfer) begin
         shreg_q <= buf_full_q ? buf_q : `TX_RST_WORD;
      end else if (bclk_rise & running) begin
         shreg_q <= {shreg_q[30:0], 1'b0};
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         buf_q <= `TX_RST_WORD;
         buf_full_q <= 1'b0;
         dma_cnt_q <= 5'd0;
      end else begin
         if (I_DMA_WRITE & ((dma_cnt_q == 5'd0) | xfer)) begin
            buf_q <= I_DMA_WRITEDATA;
         end
         if (!rel) begin
            buf_full_q <= 1'b0;
            dma_cnt_q <= 5'd0;
         end else if (xfer) begin
            buf_full_q <= I_DMA_WRITE;
            dma_cnt_q <= {4'h0, I_DMA_WRITE};
         end else if (I_DMA_WRITE) begin
            buf_full_q <= 1'b1;
            dma_cnt_q <= (dma_cnt_q == 5'd31) ? dma_cnt_q : dma_cnt_q + 5'd1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         oe_q <= 1'b0;
         dma_req_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         oe_q <= (link_d == LINK_RUN) & mask_q[slot_d[4:0]];
         dma_req_q <= ev_drdy;
         irq_q <= (|pend_d) & ~collide;
      end
   end
   assign O_TX_DATA = shreg_q[31] & oe_q;
   assign O_TX_DATA_OE = oe_q;
   assign O_TX_DMA_REQ = dma_req_q;
   assign O_TX_IRQ = irq_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   a_silent_slot: assert property (O_TX_DATA_OE |-> $past(mask_q[slot_d[4:0]]))
      else $error("driving in masked slot");
   a_mask_modulo: assert property ((link_d == LINK_RUN) && mask_q[slot_d[4:0]] |=> O_TX_DATA_OE)
      else $error("active slot not driven");
   a_slot_span: assert property (slot_q <= 9'd383)
      else $error("slot counter beyond span");
   a_irq_level: assert property ((|pend_d) && !collide |=> O_TX_IRQ)
      else $error("enabled flag without interrupt");
   a_irq_quiet: assert property (!(|pend_d) |=> !O_TX_IRQ)
      else $error("interrupt without enabled flag");
   a_reserved_zero: assert property (word_sel == `TX_OFS_STATUS |-> rdata_d[31:9] == 23'h0)
      else $error("reserved status bits nonzero");
   a_set_wins: assert property (|set_vec |=> (flags_q & $past(set_vec)) == $past(set_vec))
      else $error("hardware set lost");
   a_refire: assert property (collide |=> !O_TX_IRQ)
      else $error("no fresh interrupt edge");
   a_err_summary: assert property (word_sel == `TX_OFS_STATUS |-> rdata_d[8] == (|(flags_q & 8'h87)))
      else $error("error summary wrong");
   a_w1c_clear: assert property (|(clr & ~set_vec) |=> (flags_q & $past(clr & ~set_vec)) == 8'h0)
      else $error("flag not cleared");
   a_dma_req: assert property (set_vec[`TX_ST_DRDY] |=> O_TX_DMA_REQ)
      else $error("data ready without DMA request");
   a_last_ready: assert property (set_vec[`TX_ST_LAST] |-> set_vec[`TX_ST_DRDY])
      else $error("last slot without data ready");
   a_reset_slot: assert property (!rel |=> slot_q == 9'd383)
      else $error("slot counter not held");
   a_sync_early: assert property (
      ev_sof && running && !bit_last |=> flags_q[`TX_ST_SYNC])
      else $error("early frame sync not flagged");
   a_under_flag: assert property (xfer && !buf_full_q |=> flags_q[`TX_ST_UNDER])
      else $error("underrun not flagged");
endmodule

// >>> tb/audio_link_model.sv
// Far-side audio receiver model: makes bit clock and frame sync, captures serial data.
module audio_link_model (
   input wire logic i_data,
   input wire logic i_data_oe,
   output logic o_bit_clk,
   output logic o_frame_sync
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] rx_word;
   int active_bits;
   initial begin
      o_bit_clk = 1'b0;
      o_frame_sync = 1'b0;
      rx_word = 32'h0;
      active_bits = 0;
   end
   // ------------------------------------------------------------------------
   // Bit clock
   // ------------------------------------------------------------------------
   // The clock runs only inside frames and rests low between calls.
   // Sync is raised ahead of the rising edge so that edge samples it high.
   // Data is taken on the falling edge, half a period after the block shifts.
   task automatic run_bits(input int n, input bit sync);
      for (int i = 0; i < n; i++) begin
         o_frame_sync = sync && (i == 0);
         #62.5 o_bit_clk = 1'b1;
         #62.5 o_bit_clk = 1'b0;
         rx_word = {rx_word[30:0], i_data};
         if (i_data_oe === 1'b1) active_bits++;
      end
      o_frame_sync = 1'b0;
   endtask
endmodule

// >>> tb/audio_tx_slot_irq_status_tb.sv
// Self-checking bench for the transmit slot, interrupt and status block.
module audio_tx_slot_irq_status_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] ofs_mask = 5'h00;
   localparam logic [4:0] ofs_irqen = 5'h04;
   localparam logic [4:0] ofs_stat = 5'h08;
   localparam logic [4:0] ofs_slot = 5'h0c;
   localparam logic [4:0] ofs_ctrl = 5'h10;
   localparam logic [4:0] ofs_none = 5'h1c;
   logic clk, rst_n, rd, wr, dma_wr, clk_fault, irq_d;
   logic [4:0] addr;
   logic [31:0] wdata, dma_data, rdata;
   logic [3:0] be;
   wire logic [31:0] rdata_w;
   wire logic wait_req, tx_data, tx_oe, dma_req, irq, bit_clk, fsync;
   int bad_count, samples_checked, dma_pulses, irq_rises, p, a;
   audio_tx_slot_irq_status audio_tx_slot_irq_status_inst (
      .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
      .O_AVS_READDATA(rdata_w), .O_AVS_WAITREQUEST(wait_req), .I_DMA_WRITE(dma_wr),
      .I_DMA_WRITEDATA(dma_data), .I_CLK_FAULT(clk_fault), .I_TX_BIT_CLK(bit_clk),
      .I_TX_FRAME_SYNC(fsync), .O_TX_DATA(tx_data), .O_TX_DATA_OE(tx_oe),
      .O_TX_DMA_REQ(dma_req), .O_TX_IRQ(irq));
   audio_link_model audio_link_model_inst (
      .i_data(tx_data), .i_data_oe(tx_oe), .o_bit_clk(bit_clk), .o_frame_sync(fsync));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      irq_d <= irq;
      if (dma_req === 1'b1) dma_pulses <= dma_pulses + 1;
      if (irq === 1'b1 && irq_d !== 1'b1) irq_rises <= irq_rises + 1;
   end
   // ------------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------------
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   // Held until waitrequest is seen low; the next request waits one more edge.
   task automatic bus_xfer(input logic is_wr, input logic [4:0] a_in, input logic [31:0] d);
      addr <= a_in;
      wdata <= d;
      wr <= is_wr;
      rd <= !is_wr;
      do begin
         @(posedge clk);
      end while (wait_req !== 1'b0);
      rdata = rdata_w;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr_reg(input logic [4:0] a_in, input logic [31:0] d);
      bus_xfer(1'b1, a_in, d);
   endtask
   task automatic rd_chk(input logic [4:0] a_in, input logic [31:0] m, input logic [31:0] e,
                         input string s);
      bus_xfer(1'b0, a_in, 32'h0);
      check_word(rdata & m, e, s);
   endtask
   // The link clock is slow, so give the synchronisers time before the next access.
   task automatic link_run(input int n, input bit sync);
      audio_link_model_inst.run_bits(n, sync);
      repeat (8) @(posedge clk);
   endtask
   task automatic dma_push(input int n);
      dma_wr <= 1'b1;
      dma_data <= 32'ha5c3_0f1e;
      repeat (n) @(posedge clk);
      dma_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------------
   task automatic test_reset();
      check_word({29'h0, irq, tx_oe, dma_req}, 32'h0, "outputs idle");
      rd_chk(ofs_mask, '1, 32'h0, "mask reset");
      rd_chk(ofs_irqen, '1, 32'h0, "enable reset");
      rd_chk(ofs_stat, 32'hffff_fff7, 32'h0, "status reset");
      rd_chk(ofs_slot, '1, 32'h17f, "slot in reset");
      rd_chk(ofs_stat, 32'h8, 32'h8, "parity of 383");
      rd_chk(ofs_none, '1, 32'h0, "unmapped read");
   endtask
   task automatic test_regs();
      wr_reg(ofs_mask, 32'h8000_0001);
      wr_reg(ofs_none, 32'h0);
      rd_chk(ofs_mask, '1, 32'h8000_0001, "mask rw");
      wr_reg(ofs_irqen, 32'hffff_ffff);
      rd_chk(ofs_irqen, '1, 32'h0000_00bf, "enable bits");
      wr_reg(ofs_irqen, 32'h0);
      wr_reg(ofs_slot, 32'h0);
      rd_chk(ofs_slot, '1, 32'h17f, "slot read only");
   endtask
   task automatic test_release_irq();
      p = dma_pulses;
      wr_reg(ofs_ctrl, 32'h0001_0011);
      repeat (4) @(posedge clk);
      rd_chk(ofs_stat, 32'h20, 32'h20, "ready on release");
      check_word(32'(dma_pulses - p), 32'h1, "dma on release");
      check_word({31'h0, irq}, 32'h0, "irq masked");
      wr_reg(ofs_irqen, 32'h20);
      repeat (3) @(posedge clk);
      check_word({31'h0, irq}, 32'h1, "irq enabled");
      wr_reg(ofs_stat, 32'h0);
      rd_chk(ofs_stat, 32'h20, 32'h20, "write zero keeps");
      wr_reg(ofs_stat, 32'h20);
      repeat (3) @(posedge clk);
      rd_chk(ofs_stat, 32'h20, 32'h0, "write one clears");
      check_word({31'h0, irq}, 32'h0, "irq drops");
   endtask
   task automatic test_fault_collision();
      wr_reg(ofs_irqen, 32'h04);
      clk_fault <= 1'b1;
      @(posedge clk);
      clk_fault <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk(ofs_stat, 32'h104, 32'h104, "fault and summary");
      p = irq_rises;
      clk_fault <= 1'b1;
      wr_reg(ofs_stat, 32'h4);
      clk_fault <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk(ofs_stat, 32'h4, 32'h4, "set beats clear");
      check_word(32'(irq_rises - p), 32'h1, "fresh irq");
      wr_reg(ofs_stat, 32'h4);
      repeat (3) @(posedge clk);
      rd_chk(ofs_stat, 32'h104, 32'h0, "fault cleared");
      check_word({31'h0, irq}, 32'h0, "irq idle");
      wr_reg(ofs_irqen, 32'h0);
   endtask
   task automatic test_dma_error();
      dma_push(2);
      rd_chk(ofs_stat, 32'h180, 32'h180, "dma overwrite");
      wr_reg(ofs_stat, 32'hff);
   endtask
   // Two-slot frame: slot 0 active with data, slot 1 masked off but refilled.
   task automatic test_frame_mask();
      p = dma_pulses;
      link_run(32, 1'b1);
      check_word(audio_link_model_inst.rx_word, 32'ha5c3_0f1e, "slot 0 data");
      check_word(32'(audio_link_model_inst.active_bits), 32'd32, "slot 0 oe");
      rd_chk(ofs_stat, 32'h1ff, 32'h060, "slot 0 flags");
      rd_chk(ofs_slot, '1, 32'h0, "first slot");
      check_word(32'(dma_pulses - p), 32'h1, "slot 0 dma");
      wr_reg(ofs_stat, 32'hff);
      dma_push(1);
      p = dma_pulses;
      link_run(32, 1'b0);
      check_word(audio_link_model_inst.rx_word, 32'h0, "slot 1 silent");
      check_word(32'(audio_link_model_inst.active_bits), 32'd32, "slot 1 oe");
      rd_chk(ofs_stat, 32'h1ff, 32'h038, "last slot flags");
      check_word(32'(dma_pulses - p), 32'h1, "slot 1 dma");
   endtask
   // Thirty-three slots: mask bit 0 must also open slot 32, bit 31 opens slot 31.
   task automatic test_long_frame_sync();
      wr_reg(ofs_ctrl, 32'h0001_0201);
      wr_reg(ofs_stat, 32'hff);
      a = audio_link_model_inst.active_bits;
      link_run(33 * 32, 1'b1);
      check_word(32'(audio_link_model_inst.active_bits - a), 32'd96, "mask modulo");
      // Sync comes in slot 1 of a frame now 33 slots long, and no word is ever refilled.
      rd_chk(ofs_stat, 32'h1ff, 32'h143, "underrun frame");
      rd_chk(ofs_slot, '1, 32'h20, "slot past 31");
      wr_reg(ofs_stat, 32'hff);
      link_run(4, 1'b1);
      rd_chk(ofs_stat, 32'h42, 32'h40, "timely sync");
      link_run(4, 1'b1);
      rd_chk(ofs_stat, 32'h102, 32'h102, "early sync");
   endtask
   // ------------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h0;
      wdata = 32'h0;
      be = 4'hf;
      dma_wr = 1'b0;
      dma_data = 32'h0;
      clk_fault = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      test_reset();
      test_regs();
      test_release_irq();
      test_fault_collision();
      test_dma_error();
      test_frame_mask();
      test_long_frame_sync();
      finish_test();
   end
   initial begin
      #200us;
      bad_count++;
      finish_test();
   end
endmodule
